// ==== inc/sacg_consts.vh ====
// Operation
// - converter needs only convert_start_n; it times its own approximation internally.
// - convert start comes from internal generator or external source via select.
// - internal convert start period is cnv_ratio master clocks, set by the cnv_ratio input.
// - master clock is the single core_clk input; there is no clock source select.
// - in serial slave mode the serial bit clock equals the master clock.
// - while busy is active, drive indicator on and expose busy at monitor.
// - results go to host on 16-bit bus, whole-word or byte-wide transfers.
// - capture full 18-bit result; host reads it as two consecutive words, or three consecutive bytes in byte mode.
// - bus updates on falling host_side_busy and rising header_side_busy_n.
// - buffered 16-bit bus carries results in parallel and serial modes.
// - control low: generate starts, buffer data, hold select asserted, and read asserted outside serial mode.
`ifndef SACG_CONSTS_VH
`define SACG_CONSTS_VH
`define SACG_CLK_MHZ 40
`define SACG_CNV_RATIO 16'd40
`define SACG_CNV_LOW 16'd4
`define SACG_RES_W 18
`define SACG_BUS_W 16
`define SACG_SER_BITS 5'd18
`endif

// ==== rtl/sacg_sync.v ====
`timescale 1ns/1ps
module sacg_sync (
  input wire core_clk,
  input wire arst_n,
  input wire din,
  output reg dout
);
  reg stage;
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage <= 1'b0;
      dout <= 1'b0;
    end else begin
      stage <= din;
      dout <= stage;
    end
  end
endmodule

// ==== rtl/sacg_start_gen.v ====
`timescale 1ns/1ps
`include "sacg_consts.vh"
module sacg_start_gen (
  input wire core_clk,
  input wire arst_n,
  input wire [15:0] ratio,
  output reg start_n
);
  reg [15:0] cnt;
  // period is ratio master clocks, so it scales with the clock itself
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 16'h0000;
      start_n <= 1'b1;
    end else begin
      if (cnt >= ratio - 16'h0001) begin
        cnt <= 16'h0000;
      end else begin
        cnt <= cnt + 16'h0001;
      end
      start_n <= (cnt >= `SACG_CNV_LOW);
    end
  end
endmodule

// ==== rtl/sacg_top.v ====
`timescale 1ns/1ps
`include "sacg_consts.vh"
module sacg_top (
  input wire core_clk,
  input wire arst_n,
  input wire control,
  input wire external_start_select,
  input wire ext_convert_start_n,
  input wire [15:0] cnv_ratio,
  input wire serial_mode,
  input wire serial_slave,
  input wire byte_mode,
  input wire conv_busy,
  input wire [17:0] adc_par_data,
  input wire serial_result_out,
  input wire host_read_strobe,
  output wire convert_start_n,
  output wire adc_cs_n,
  output wire adc_rd_n,
  output wire adc_sclk,
  output wire busy_led,
  output wire busy_monitor,
  output reg [15:0] buffered_conv_data,
  output reg host_side_busy,
  output reg header_side_busy_n,
  output reg read_overrun_flag,
  output reg word_phase
);
  wire s_busy;
  wire s_ext;
  wire s_sdo;
  wire s_rd;
  wire gen_start_n;
  reg busy_q;
  reg act_q;
  reg rd_q;
  wire [17:0] fresh;
  reg [17:0] result;
  reg [17:0] shift;
  reg [4:0] bit_cnt;
  reg shifting;
  reg [1:0] part;
  reg unread;
  reg [15:0] next_bus;

  sacg_sync u_sb (.core_clk(core_clk), .arst_n(arst_n), .din(conv_busy), .dout(s_busy));
  // synchronised inverted so the reset value matches the idle-high pin: no false start after reset
  sacg_sync u_se (.core_clk(core_clk), .arst_n(arst_n), .din(~ext_convert_start_n), .dout(s_ext));
  sacg_sync u_sd (.core_clk(core_clk), .arst_n(arst_n), .din(serial_result_out), .dout(s_sdo));
  sacg_sync u_sr (.core_clk(core_clk), .arst_n(arst_n), .din(host_read_strobe), .dout(s_rd));

  sacg_start_gen u_gen (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .ratio(cnv_ratio),
    .start_n(gen_start_n)
  );

  // the converter times its own approximation; only this strobe is sent
  assign convert_start_n = external_start_select ? ~s_ext : gen_start_n;
  // stand-alone keeps the parallel port permanently selected, and read only outside serial mode
  assign adc_cs_n = control;
  assign adc_rd_n = control | serial_mode;
  // clock pass-through; the master clock itself, not a divided copy
  assign adc_sclk = serial_mode & serial_slave & core_clk;
  assign busy_led = s_busy;
  assign busy_monitor = s_busy;

  wire busy_fall = busy_q & ~s_busy;
  assign fresh = serial_mode ? result : adc_par_data;
  wire rd_rise = s_rd & ~rd_q;

  always @* begin
    // part is the unit now shown; this is the unit a read moves on to (low first, wraps)
    next_bus = 16'h0000;
    if (byte_mode) begin
      case (part)
        2'd0: next_bus = {8'h00, result[15:8]};
        2'd1: next_bus = {14'h0000, result[17:16]};
        2'd2: next_bus = {8'h00, result[7:0]};
        default: next_bus = 16'h0000;
      endcase
    end else begin
      case (part)
        2'd0: next_bus = {14'h0000, result[17:16]};
        2'd1: next_bus = result[15:0];
        default: next_bus = 16'h0000;
      endcase
    end
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_q <= 1'b0;
      act_q <= 1'b0;
      rd_q <= 1'b0;
      result <= 18'h00000;
      shift <= 18'h00000;
      bit_cnt <= 5'd0;
      shifting <= 1'b0;
      part <= 2'd0;
      unread <= 1'b0;
      buffered_conv_data <= 16'h0000;
      host_side_busy <= 1'b0;
      header_side_busy_n <= 1'b1;
      read_overrun_flag <= 1'b0;
      word_phase <= 1'b0;
    end else begin
      busy_q <= s_busy;
      act_q <= s_busy | shifting;
      rd_q <= s_rd;
      host_side_busy <= s_busy | shifting;
      header_side_busy_n <= ~(s_busy | shifting);
      if (serial_mode) begin
        if (busy_fall) begin
          shifting <= 1'b1;
          bit_cnt <= 5'd0;
        end else if (shifting) begin
          shift <= {shift[16:0], s_sdo};
          bit_cnt <= bit_cnt + 5'd1;
          if (bit_cnt == `SACG_SER_BITS - 5'd1) begin
            shifting <= 1'b0;
            result <= {shift[16:0], s_sdo};
          end
        end
      end else if (busy_fall) begin
        result <= adc_par_data;
      end
      // new result is published only once busy (and shifting) is over
      // act_q remembers the last cycle of activity, so the serial end is seen after result is loaded
      if (act_q & ~(s_busy | shifting)) begin
        part <= 2'd0;
        buffered_conv_data <= byte_mode ? {8'h00, fresh[7:0]} : fresh[15:0];
        word_phase <= 1'b0;
        read_overrun_flag <= unread;
        unread <= 1'b1;
      end else if (rd_rise & ~(s_busy | shifting)) begin
        // the last word wraps back to the first, so a re-read stays consistent
        if ((byte_mode && part == 2'd2) || (!byte_mode && part == 2'd1)) begin
          part <= 2'd0;
          unread <= 1'b0;
        end else begin
          part <= part + 2'd1;
        end
        buffered_conv_data <= next_bus;
        word_phase <= ~word_phase;
      end
    end
  end
endmodule

// ==== tb/sacg_props.sv ====
`timescale 1ns/1ps
module sacg_props (
  input wire core_clk,
  input wire arst_n,
  input wire control,
  input wire external_start_select,
  input wire ext_convert_start_n,
  input wire serial_mode,
  input wire conv_busy,
  input wire convert_start_n,
  input wire adc_cs_n,
  input wire adc_rd_n,
  input wire busy_monitor,
  input wire [15:0] buffered_conv_data,
  input wire host_side_busy,
  input wire header_side_busy_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  a_cs_held: assert property (adc_cs_n == control) else $error("cs");
  a_rd_held: assert property (adc_rd_n == (control | serial_mode)) else $error("rd");
  a_busy_seen: assert property ($fell(conv_busy) |-> ##[1:3] !busy_monitor) else $error("busy");
  a_bus_frozen: assert property (host_side_busy && $past(host_side_busy) |->
    $stable(buffered_conv_data)) else $error("bus");
  a_busy_edges: assert property ($fell(host_side_busy) |-> $rose(header_side_busy_n)) else $error("edge");
  a_busy_pair: assert property (header_side_busy_n != host_side_busy) else $error("pair");
  a_start_width: assert property (!external_start_select && $fell(convert_start_n) |->
    !convert_start_n [*4] ##1 convert_start_n) else $error("width");
  a_ext_pass: assert property (external_start_select && $fell(ext_convert_start_n) |->
    ##[1:3] $fell(convert_start_n)) else $error("ext");
  c_result: cover property ($fell(host_side_busy));
  c_internal: cover property (!external_start_select && $fell(convert_start_n));
  c_external: cover property (external_start_select && $fell(convert_start_n));
endmodule

// ==== tb/sacg_adc_model.sv ====
`timescale 1ns/1ps
module sacg_adc_model (
  input wire core_clk,
  input wire convert_start_n,
  input wire [17:0] sample,
  output reg conv_busy = 1'b0,
  output reg [17:0] adc_par_data = 18'h0
);
  reg last_n = 1'b1;
  reg [3:0] left = 4'h0;
  always @(posedge core_clk) begin
    last_n <= convert_start_n;
    if (last_n && !convert_start_n) begin
      conv_busy <= 1'b1;
      left <= 4'ha;
      // junk while converting, so an early latch is caught
      adc_par_data <= ~sample;
    end else if (left != 4'h0) begin
      left <= left - 4'h1;
      conv_busy <= left != 4'h1;
      if (left == 4'h1) adc_par_data <= sample;
    end
  end
endmodule

// ==== tb/test_sar_adc_conversion_glue.sv ====
`timescale 1ns/1ps
module test_sar_adc_conversion_glue;
  reg core_clk = 1'b0, arst_n = 1'b0, es = 1'b0, en = 1'b1, bm = 1'b0, rs = 1'b0;
  reg [17:0] sample = 18'h2a5c3;
  wire busy, hb, cn;
  wire [17:0] pd;
  wire [15:0] bus;
  integer num_errors = 0, checked = 0;
  sacg_top dut (.core_clk(core_clk), .arst_n(arst_n), .control(1'b0), .external_start_select(es),
    .ext_convert_start_n(en), .cnv_ratio(16'd60), .serial_mode(1'b0), .serial_slave(1'b0), .byte_mode(bm),
    .conv_busy(busy), .adc_par_data(pd), .serial_result_out(1'b0), .host_read_strobe(rs), .convert_start_n(cn),
    .adc_cs_n(), .adc_rd_n(), .adc_sclk(), .busy_led(), .busy_monitor(), .buffered_conv_data(bus),
    .host_side_busy(hb), .header_side_busy_n(), .read_overrun_flag(), .word_phase());
  sacg_adc_model adc (.core_clk(core_clk), .convert_start_n(cn), .sample(sample), .conv_busy(busy), .adc_par_data(pd));
  task check(input [15:0] seen, input [15:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("mismatch buffered_conv_data expected %h seen %h", exp, seen);
      end
    end
  endtask
  task results;
    begin
      if (num_errors == 0 && checked > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  // sampled on falling edges so the bus has settled
  task wait_result;
    begin
      repeat (100) if (hb !== 1'b1) @(negedge core_clk);
      repeat (100) if (hb !== 1'b0) @(negedge core_clk);
    end
  endtask
  task read_next;
    begin
      @(posedge core_clk) rs <= 1'b1;
      repeat (3) @(posedge core_clk);
      rs <= 1'b0;
      repeat (4) @(negedge core_clk);
    end
  endtask
  task word_reads;
    begin
      wait_result;
      check(bus, sample[15:0]);
      read_next;
      check(bus, {14'h0, sample[17:16]});
    end
  endtask
  task byte_reads;
    begin
      @(posedge core_clk) bm <= 1'b1;
      sample <= 18'h15a3c;
      wait_result;
      check(bus, {8'h0, sample[7:0]});
      read_next;
      check(bus, {8'h0, sample[15:8]});
      read_next;
      check(bus, {14'h0, sample[17:16]});
    end
  endtask
  task ext_start;
    begin
      @(posedge core_clk) es <= 1'b1;
      sample <= 18'h3ffff;
      repeat (80) @(posedge core_clk);
      en <= 1'b0;
      repeat (4) @(posedge core_clk);
      en <= 1'b1;
      wait_result;
      check(bus, {8'h0, sample[7:0]});
    end
  endtask
  initial forever #12.5 core_clk = ~core_clk;
  initial begin
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    word_reads;
    byte_reads;
    ext_start;
    results;
  end
  initial begin
    repeat (2000) @(posedge core_clk);
    num_errors = num_errors + 1;
    results;
  end
endmodule
bind sacg_top sacg_props u_props (.*);
